// >>> include/pcie_err_pkg.sv
// Shared constants and carrier types for the endpoint error-status block.
// Assumes a 100 MHz system clock and an AXI4-Lite register bus.
package pcie_err_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int DETECT_LIMIT_MS = 20;
  localparam int CFG_LIMIT_MS    = 100;
  localparam int DETECT_LIMIT_CYC = DETECT_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CFG_LIMIT_CYC    = CFG_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DETECT_WAIT_DEF  = 64;
  localparam int CFG_WAIT_DEF     = 256;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFS_DEV_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DEV_STATUS = 8'h04;
  localparam logic [7:0] OFS_STATUS_CLR = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN     = 8'h0c;
  localparam logic [7:0] OFS_LINK_STATE = 8'h10;
  localparam logic [4:0] DEV_CTRL_RST   = 5'h00;
  localparam logic [3:0] IRQ_EN_RST     = 4'h0;
  localparam int CTRL_ROM_EN_BIT = 4;
  // Status vector bit positions
  localparam int ST_CORR  = 0;
  localparam int ST_NONF  = 1;
  localparam int ST_FATAL = 2;
  localparam int ST_UR    = 3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    PKT_CFG    = 3'h0,
    PKT_ROM    = 3'h1,
    PKT_MSG    = 3'h2,
    PKT_MEM_IO = 3'h3,
    PKT_CPL    = 3'h4,
    PKT_OTHER  = 3'h5
  } pkt_kind_t;
  typedef enum logic [1:0] {
    LT_RESET  = 2'h0,
    LT_DETECT = 2'h1,
    LT_UP     = 2'h2
  } ltssm_t;
  typedef struct packed {
    pkt_kind_t   kind;
    logic        bar_hit;
    logic [31:0] word;
  } rx_pkt_t;
  typedef struct packed {
    logic training;
    logic dll_proto;
    logic fc_proto;
    logic malformed;
    logic rx_overflow;
    logic correctable;
    logic nonfatal;
  } rx_err_t;
endpackage

// >>> rtl/pcie_endpoint_error_status.sv
// Endpoint error status, inbound routing and link bring-up timing.
// Assumes one 100 MHz clock, AXI4-Lite master, receive-side events
// arriving as one-cycle pulses synchronous to sys_clk.
//
// Behaviour
// - Enter detect within 20 ms of reset
// - Accept configuration requests within 100 ms
// - Configuration requests answered internally, never forwarded
// - Forward ROM, message, BAR-hit and completion packets
// - Four-bit status: correctable, non-fatal, fatal, UR
// - Error messages only when reporting enabled
// - Listed protocol faults raise fatal status
// - Transmit-side errors never set own status
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module pcie_endpoint_error_status
  import pcie_err_pkg::*;
#(
  parameter int DETECT_WAIT = DETECT_WAIT_DEF,
  parameter int CFG_WAIT    = CFG_WAIT_DEF
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Link bring-up
  input  wire logic        train_done,
  output ltssm_t           ltssm_state,
  output logic             cfg_ready,
  // Inbound packets from the link
  input  wire rx_pkt_t     rx_pkt,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire rx_err_t     rx_err,
  // Internal configuration answer
  output logic             cfg_cpl_valid,
  output logic             cfg_cpl_retry,
  // Forwarded to the application
  output rx_pkt_t          fwd_pkt,
  output logic             fwd_valid,
  input  wire logic        fwd_ready,
  // Status, upstream messages, interrupt
  output logic [3:0]       device_status_vector,
  output logic             err_msg_valid,
  output logic [3:0]       err_msg_kind,
  output logic             irq
);

  // ****************************************************************
  // Bring-up timing
  // ****************************************************************
  // Detect wait must stay within its limit, config wait within its own
  localparam int DW = (DETECT_WAIT < DETECT_LIMIT_CYC) ? DETECT_WAIT : DETECT_LIMIT_CYC;
  localparam int CW = (CFG_WAIT < CFG_LIMIT_CYC) ? CFG_WAIT : CFG_LIMIT_CYC;

  ltssm_t      lt_ff, nxt_lt;
  logic [31:0] up_cnt_ff, nxt_up_cnt;
  logic        cfg_rdy_ff, nxt_cfg_rdy;
  logic        fatal_ev;

  // Count from reset release, step the link state
  always_comb begin
    nxt_up_cnt  = up_cnt_ff;
    nxt_lt      = lt_ff;
    nxt_cfg_rdy = cfg_rdy_ff;
    if (up_cnt_ff != 32'hffffffff) begin
      nxt_up_cnt = up_cnt_ff + 32'h1;
    end
    if (up_cnt_ff >= 32'(CW - 1)) begin
      nxt_cfg_rdy = 1'b1;
    end
    case (lt_ff)
      LT_RESET:  if (up_cnt_ff >= 32'(DW - 1)) nxt_lt = LT_DETECT;
      LT_DETECT: if (train_done) nxt_lt = LT_UP;
      LT_UP:     if (rx_err.training) nxt_lt = LT_DETECT; // Retrain after a training fault
      default:   nxt_lt = LT_RESET;
    endcase
  end

  // Bring-up registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lt_ff      <= LT_RESET;
      up_cnt_ff  <= 32'h0;
      cfg_rdy_ff <= 1'b0;
    end else begin
      lt_ff      <= nxt_lt;
      up_cnt_ff  <= nxt_up_cnt;
      cfg_rdy_ff <= nxt_cfg_rdy;
    end
  end

  assign ltssm_state = lt_ff;
  assign cfg_ready   = cfg_rdy_ff;

  // ****************************************************************
  // Inbound routing
  // ****************************************************************
  logic [4:0] ctrl_ff, nxt_ctrl;
  rx_pkt_t    fwd_ff, nxt_fwd;
  logic       fwd_v_ff, nxt_fwd_v;
  logic       cpl_v_ff, nxt_cpl_v;
  logic       cpl_r_ff, nxt_cpl_r;
  logic       ur_ev;
  logic       to_app;
  logic       take;

  assign rx_ready = !fwd_v_ff || fwd_ready;
  assign take     = rx_valid && rx_ready;

  // Classify each packet: internal, forward, or unsupported
  always_comb begin
    to_app = 1'b0;
    ur_ev  = 1'b0;
    case (rx_pkt.kind)
      PKT_CFG:    to_app = 1'b0;
      PKT_ROM: begin
        to_app = ctrl_ff[CTRL_ROM_EN_BIT];
        ur_ev  = !ctrl_ff[CTRL_ROM_EN_BIT];
      end
      PKT_MSG:    to_app = 1'b1;
      PKT_MEM_IO: begin
        to_app = rx_pkt.bar_hit;
        ur_ev  = !rx_pkt.bar_hit;
      end
      PKT_CPL:    to_app = 1'b1;
      default:    ur_ev  = 1'b1;
    endcase
    ur_ev = ur_ev && take;
  end

  // Forward holding stage and config answer
  always_comb begin
    nxt_fwd   = fwd_ff;
    nxt_fwd_v = fwd_v_ff && !fwd_ready;
    nxt_cpl_v = 1'b0;
    nxt_cpl_r = 1'b0;
    if (take && to_app) begin
      nxt_fwd   = rx_pkt;
      nxt_fwd_v = 1'b1; // held until the application takes it
    end
    if (take && rx_pkt.kind == PKT_CFG) begin
      nxt_cpl_v = 1'b1;
      nxt_cpl_r = !cfg_rdy_ff; // retry until ready
    end
  end

  // Routing registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fwd_ff   <= '0;
      fwd_v_ff <= 1'b0;
      cpl_v_ff <= 1'b0;
      cpl_r_ff <= 1'b0;
    end else begin
      fwd_ff   <= nxt_fwd;
      fwd_v_ff <= nxt_fwd_v;
      cpl_v_ff <= nxt_cpl_v;
      cpl_r_ff <= nxt_cpl_r;
    end
  end

  assign fwd_pkt       = fwd_ff;
  assign fwd_valid     = fwd_v_ff;
  assign cfg_cpl_valid = cpl_v_ff;
  assign cfg_cpl_retry = cpl_r_ff;

  // ****************************************************************
  // Status vector and error messages
  // ****************************************************************
  logic [3:0] stat_ff, nxt_stat;
  logic [3:0] ev;
  logic [3:0] clr;
  logic       msg_v_ff, nxt_msg_v;
  logic [3:0] msg_k_ff, nxt_msg_k;
  logic [3:0] ien_ff, nxt_ien;

  // Only receive-side events feed the vector
  assign fatal_ev = rx_err.training | rx_err.dll_proto | rx_err.fc_proto
                  | rx_err.malformed | rx_err.rx_overflow;
  assign ev = {ur_ev, fatal_ev, rx_err.nonfatal, rx_err.correctable};

  // Sticky status, a new event beats a clear
  always_comb begin
    nxt_stat  = (stat_ff & ~clr) | ev;
    nxt_msg_v = |(ev & ctrl_ff[3:0]);
    nxt_msg_k = ev & ctrl_ff[3:0];
  end

  // Status registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stat_ff  <= 4'h0;
      msg_v_ff <= 1'b0;
      msg_k_ff <= 4'h0;
    end else begin
      stat_ff  <= nxt_stat;
      msg_v_ff <= nxt_msg_v;
      msg_k_ff <= nxt_msg_k;
    end
  end

  assign device_status_vector = stat_ff;
  assign err_msg_valid        = msg_v_ff;
  assign err_msg_kind         = msg_k_ff;
  assign irq                  = |(stat_ff & ien_ff);

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic        aw_ff, nxt_aw;
  logic [7:0]  awa_ff, nxt_awa;
  logic        w_ff, nxt_w;
  logic [31:0] wd_ff, nxt_wd;
  logic [3:0]  ws_ff, nxt_ws;
  logic        bv_ff, nxt_bv;
  logic [1:0]  br_ff, nxt_br;
  logic        rv_ff, nxt_rv;
  logic [31:0] rd_ff, nxt_rd;
  logic [1:0]  rr_ff, nxt_rr;
  logic        do_wr;

  // Decode a mapped offset
  function automatic logic is_mapped(input logic [7:0] a);
    return a == OFS_DEV_CTRL || a == OFS_DEV_STATUS || a == OFS_STATUS_CLR
        || a == OFS_IRQ_EN || a == OFS_LINK_STATE;
  endfunction

  assign s_awready = !aw_ff && !bv_ff;
  assign s_wready  = !w_ff && !bv_ff;
  assign s_arready = !rv_ff;
  assign do_wr     = aw_ff && w_ff && !bv_ff;
  assign clr       = (do_wr && awa_ff == OFS_STATUS_CLR && ws_ff[0]) ? wd_ff[3:0] : 4'h0;

  // Bus channel state and register writes
  always_comb begin
    nxt_aw   = aw_ff;
    nxt_awa  = awa_ff;
    nxt_w    = w_ff;
    nxt_wd   = wd_ff;
    nxt_ws   = ws_ff;
    nxt_bv   = bv_ff && !s_bready;
    nxt_br   = br_ff;
    nxt_rv   = rv_ff && !s_rready;
    nxt_rd   = rd_ff;
    nxt_rr   = rr_ff;
    nxt_ctrl = ctrl_ff;
    nxt_ien  = ien_ff;
    if (s_awvalid && s_awready) begin
      nxt_aw  = 1'b1;
      nxt_awa = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      nxt_w  = 1'b1;
      nxt_wd = s_wdata;
      nxt_ws = s_wstrb;
    end
    if (do_wr) begin
      nxt_aw = 1'b0;
      nxt_w  = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = is_mapped(awa_ff) ? RESP_OKAY : RESP_SLVERR;
      if (awa_ff == OFS_DEV_CTRL && ws_ff[0]) begin
        nxt_ctrl = wd_ff[4:0]; // steers forwarding and messages
      end
      if (awa_ff == OFS_IRQ_EN && ws_ff[0]) begin
        nxt_ien = wd_ff[3:0];
      end
    end
    if (s_arvalid && s_arready) begin
      nxt_rv = 1'b1;
      nxt_rr = is_mapped(s_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_araddr)
        OFS_DEV_CTRL:   nxt_rd = {27'h0, ctrl_ff};
        OFS_DEV_STATUS: nxt_rd = {28'h0, stat_ff};
        OFS_IRQ_EN:     nxt_rd = {28'h0, ien_ff};
        OFS_LINK_STATE: nxt_rd = {29'h0, cfg_rdy_ff, lt_ff};
        default:        nxt_rd = 32'h0;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aw_ff   <= 1'b0;
      awa_ff  <= 8'h00;
      w_ff    <= 1'b0;
      wd_ff   <= 32'h0;
      ws_ff   <= 4'h0;
      bv_ff   <= 1'b0;
      br_ff   <= RESP_OKAY;
      rv_ff   <= 1'b0;
      rd_ff   <= 32'h0;
      rr_ff   <= RESP_OKAY;
      ctrl_ff <= DEV_CTRL_RST;
      ien_ff  <= IRQ_EN_RST;
    end else begin
      aw_ff   <= nxt_aw;
      awa_ff  <= nxt_awa;
      w_ff    <= nxt_w;
      wd_ff   <= nxt_wd;
      ws_ff   <= nxt_ws;
      bv_ff   <= nxt_bv;
      br_ff   <= nxt_br;
      rv_ff   <= nxt_rv;
      rd_ff   <= nxt_rd;
      rr_ff   <= nxt_rr;
      ctrl_ff <= nxt_ctrl;
      ien_ff  <= nxt_ien;
    end
  end

  assign s_bvalid = bv_ff;
  assign s_bresp  = br_ff;
  assign s_rvalid = rv_ff;
  assign s_rdata  = rd_ff;
  assign s_rresp  = rr_ff;

endmodule

// >>> verification/app_model.sv
// Application-side model: drains forwarded packets, stalls at random.
// Assumes the bench seeds the generator and reads the got queue.
`timescale 1ns/1ps
module app_model
  import pcie_err_pkg::*;
(
  input  wire logic    sys_clk,
  input  wire logic    nrst,
  input  wire rx_pkt_t fwd_pkt,
  input  wire logic    fwd_valid,
  output logic         fwd_ready
);
  logic [31:0] got[$];
  // Take every forward; no transmit path, so nothing malformed or over credit
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fwd_ready <= 1'h0;
    end else begin
      fwd_ready <= ($urandom % 3) != 0;
      if (fwd_valid && fwd_ready) got.push_back(fwd_pkt.word);
    end
  end
endmodule

// >>> verification/pcie_endpoint_error_status_tb_top.sv
// Self-checking bench for the endpoint error-status block.
// Assumes the package, design, checker and application model compiled first.
`timescale 1ns/1ps
module pcie_endpoint_error_status_tb_top;
  import pcie_err_pkg::*;
  localparam int DW = 8;
  localparam int CW = 16;
  logic sys_clk = '0, nrst = '0, s_awvalid = '0, s_wvalid = '0, s_bready = '0;
  logic s_arvalid = '0, s_rready = '0, train_done = '0, rx_valid = '0, rom_en = '0, cfg_up = '0;
  logic [7:0] s_awaddr = '0, s_araddr = '0;
  logic [31:0] s_wdata = '0, s_rdata, rdat;
  logic [3:0] s_wstrb = 4'hf, device_status_vector, err_msg_kind, es, msg_seen = '0;
  logic [1:0] s_bresp, s_rresp, rrsp;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, cfg_ready, rx_ready;
  logic cfg_cpl_valid, cfg_cpl_retry, fwd_valid, fwd_ready, err_msg_valid, irq;
  ltssm_t ltssm_state;
  rx_pkt_t rx_pkt = '0, fwd_pkt;
  rx_err_t rx_err = '0;
  logic [31:0] exp_q[$];
  int num_errors = 0, checked = 0, n;
  pcie_endpoint_error_status #(.DETECT_WAIT(DW), .CFG_WAIT(CW))
    pcie_endpoint_error_status_inst (.*);
  app_model app_model_inst (.*);
  always #5 sys_clk = ~sys_clk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    checked++;
    if (got !== ex) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One bounded wait step
  task automatic tick(inout int k);
    @(posedge sys_clk);
    k++;
    if (k > 400) begin
      num_errors++;
      stop_test();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    int k = 0;
    @(posedge sys_clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= '1;
    s_wvalid <= '1;
    s_bready <= '1;
    do begin
      tick(k);
      if (s_awready) s_awvalid <= '0;
      if (s_wready) s_wvalid <= '0;
    end while (!s_bvalid);
    s_bready <= '0;
    rrsp = s_bresp;
  endtask
  task automatic rd(logic [7:0] a);
    int k = 0;
    @(posedge sys_clk);
    s_araddr <= a;
    s_arvalid <= '1;
    s_rready <= '1;
    do begin
      tick(k);
      if (s_arready) s_arvalid <= '0;
    end while (!s_rvalid);
    s_rready <= '0;
    rdat = s_rdata;
    rrsp = s_rresp;
  endtask
  task automatic snd(pkt_kind_t t, logic h);
    int k = 0;
    rx_pkt_t p;
    logic [2:0] cpl;
    p = '{kind: t, bar_hit: h, word: $urandom};
    @(posedge sys_clk);
    rx_pkt <= p;
    rx_valid <= '1;
    do tick(k); while (!rx_ready);
    rx_valid <= '0;
    rx_pkt <= ~p;
    if (t inside {PKT_MSG, PKT_CPL} || (t == PKT_MEM_IO && h) || (t == PKT_ROM && rom_en))
      exp_q.push_back(p.word);
    #1;
    cpl = {cfg_cpl_valid, cfg_cpl_retry, fwd_valid};
    if (t == PKT_CFG) chk("cfg answer", {1'b1, !cfg_up, 1'b0}, cpl);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(28994));
    repeat (3) @(posedge sys_clk);
    nrst <= '1;
    n = 0;
    while (ltssm_state !== LT_DETECT) tick(n);
    chk("detect time", 1, n <= DW + 1);
    train_done <= '1;
    snd(PKT_CFG, '0);
    n += 2; // Edges spent by the early request
    while (cfg_ready !== 1'h1) tick(n);
    chk("cfg ready time", 1, n <= CW + 1);
    cfg_up = '1;
    rd(OFS_LINK_STATE);
    chk("link state", 3'h6, rdat[2:0]);
    rd(8'h20);
    chk("unmapped read", RESP_SLVERR, rrsp);
    $display("test bring-up done");
    // Every class with and without window hit, ROM off then on
    for (int r = 0; r < 2; r++) begin
      for (int t = 0; t < 6; t++) begin
        snd(pkt_kind_t'(t), '0);
        snd(pkt_kind_t'(t), '1);
      end
      wr(OFS_DEV_CTRL, 32'h10);
      rom_en = '1;
    end
    n = 0;
    while (app_model_inst.got.size() < exp_q.size()) tick(n);
    chk("forward count", exp_q.size(), app_model_inst.got.size());
    foreach (exp_q[i]) chk("forward word", exp_q[i], app_model_inst.got[i]);
    rd(OFS_DEV_STATUS);
    chk("unsupported", 4'h8, rdat[3:0]);
    wr(OFS_STATUS_CLR, 32'hf);
    $display("test routing done");
    wr(OFS_DEV_CTRL, 32'h05);
    chk("write resp", RESP_OKAY, rrsp);
    wr(OFS_IRQ_EN, 32'h04);
    wr(8'h24, 32'hf);
    chk("unmapped write", RESP_SLVERR, rrsp);
    for (int i = 0; i < 7; i++) begin
      es = (i == 0) ? 4'h2 : (i == 1) ? 4'h1 : 4'h4;
      @(posedge sys_clk);
      rx_err <= rx_err_t'(7'h01 << i);
      @(posedge sys_clk);
      rx_err <= '0;
      @(posedge sys_clk);
      msg_seen = err_msg_valid ? err_msg_kind : 4'h0; // Pulse as it stood before this edge
      #1;
      chk("status", es, device_status_vector);
      chk("message", es & 4'h5, msg_seen);
      chk("irq", |(es & 4'h4), irq);
      wr(OFS_STATUS_CLR, 32'hf);
      #1;
      chk("cleared", 0, {irq, device_status_vector});
    end
    $display("test errors done");
    stop_test();
  end
endmodule

// >>> verification/pcie_err_checker.sv
// Assertion checker for the endpoint error-status block.
// Assumes it is bound to the top module; a single clock domain.
`timescale 1ns/1ps
module pcie_err_checker
  import pcie_err_pkg::*;
#(
  parameter int DETECT_WAIT = DETECT_WAIT_DEF,
  parameter int CFG_WAIT    = CFG_WAIT_DEF
) (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic [7:0] s_awaddr,
  input wire logic       s_awvalid,
  input wire logic [31:0] s_wdata,
  input wire logic       s_wvalid,
  input wire logic       s_bvalid,
  input wire rx_pkt_t    rx_pkt,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire rx_err_t    rx_err,
  input wire logic       cfg_cpl_valid,
  input wire rx_pkt_t    fwd_pkt,
  input wire logic       fwd_valid,
  input wire logic [3:0] device_status_vector,
  input wire logic       err_msg_valid,
  input wire logic [3:0] err_msg_kind,
  input wire ltssm_t     ltssm_state,
  input wire logic       cfg_ready
);
  logic [7:0] adr_ff;
  logic [3:0] dat_ff;
  logic [3:0] ctl_ff;
  logic       bv_ff;
  int         cnt_ff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Shadow of report enables, cycles since reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      adr_ff <= 8'h00;
      dat_ff <= 4'h0;
      ctl_ff <= 4'h0;
      bv_ff <= 1'b0;
      cnt_ff <= 0;
    end else begin
      if (s_awvalid) adr_ff <= s_awaddr;
      if (s_wvalid) dat_ff <= s_wdata[3:0];
      if (s_bvalid && !bv_ff && adr_ff == OFS_DEV_CTRL) ctl_ff <= dat_ff;
      bv_ff <= s_bvalid;
      if (cnt_ff < 1000) cnt_ff <= cnt_ff + 1;
    end
  end
  // ****
  // Properties; bits 6:2 of the error struct are the fatal faults
  // ****
  a_fatal_set: assert property (|rx_err[6:2] |=> device_status_vector[ST_FATAL])
    else $error("fatal bit missed");
  a_fatal_cause: assert property ($rose(device_status_vector[ST_FATAL])
      |-> $past(|rx_err[6:2]))
    else $error("fatal bit without cause");
  a_corr_set: assert property (rx_err.correctable |=> device_status_vector[ST_CORR])
    else $error("correctable bit missed");
  a_ur_cause: assert property ($rose(device_status_vector[ST_UR])
      |-> $past(rx_valid && rx_ready && rx_pkt.kind != PKT_CFG))
    else $error("unsupported bit without cause");
  a_cfg_internal: assert property (rx_valid && rx_ready && rx_pkt.kind == PKT_CFG
      |=> cfg_cpl_valid && !fwd_valid)
    else $error("configuration request leaked");
  a_fwd_class: assert property (rx_valid && rx_ready
      && (rx_pkt.kind inside {PKT_MSG, PKT_CPL} || (rx_pkt.kind == PKT_MEM_IO && rx_pkt.bar_hit))
      |=> fwd_valid && fwd_pkt == $past(rx_pkt))
    else $error("packet not forwarded");
  a_msg_gated: assert property (err_msg_valid |-> (err_msg_kind & ~ctl_ff) == 4'h0)
    else $error("message while reporting off");
  a_detect_bound: assert property (cnt_ff >= DETECT_WAIT |-> ltssm_state != LT_RESET)
    else $error("detect entered late");
  a_cfg_bound: assert property (cnt_ff >= CFG_WAIT |-> cfg_ready)
    else $error("configuration ready late");
endmodule
bind pcie_endpoint_error_status pcie_err_checker #(
  .DETECT_WAIT(DETECT_WAIT),
  .CFG_WAIT   (CFG_WAIT)
) pcie_err_checker_inst (
  .sys_clk             (sys_clk),
  .nrst                (nrst),
  .s_awaddr            (s_awaddr),
  .s_awvalid           (s_awvalid),
  .s_wdata             (s_wdata),
  .s_wvalid            (s_wvalid),
  .s_bvalid            (s_bvalid),
  .rx_pkt              (rx_pkt),
  .rx_valid            (rx_valid),
  .rx_ready            (rx_ready),
  .rx_err              (rx_err),
  .cfg_cpl_valid       (cfg_cpl_valid),
  .fwd_pkt             (fwd_pkt),
  .fwd_valid           (fwd_valid),
  .device_status_vector(device_status_vector),
  .err_msg_valid       (err_msg_valid),
  .err_msg_kind        (err_msg_kind),
  .ltssm_state         (ltssm_state),
  .cfg_ready           (cfg_ready)
);
